// ### ddrir_ctrl.v
// DDR memory power-up initialization and refresh sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ddrir_defines.vh"

module ddrir_ctrl #(
    parameter PER_W = 16,
    parameter GRP_W = 4
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // AXI4-Lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // User side
    input wire clock_manager_locked,
    input wire [9:0] init_parms,
    input wire ref_auto_sel,
    input wire [19:0] ref_parms,
    input wire [2:0] user_cmd,
    input wire access_busy,
    output reg req_accept,
    output reg refresh_hold,
    output reg init_done,
    // Memory command pins
    output reg mem_csb,
    output reg mem_fn,
    output reg mem_pdb,
    output reg [14:0] mem_ad,
    output reg [1:0] mem_ba
);

    ////////////////////////////////////////////////////////////////////////
    localparam S_LOCK = 5'd0;
    localparam S_DESELECT_CMD = 5'd1;
    localparam S_RMRS1 = 5'd2;
    localparam S_RMRS2 = 5'd3;
    localparam S_HOLD1 = 5'd4;
    localparam S_CHG = 5'd5;
    localparam S_HOLD2 = 5'd6;
    localparam S_EMRS1 = 5'd7;
    localparam S_EMRS2 = 5'd8;
    localparam S_MRS1 = 5'd9;
    localparam S_MRS2 = 5'd10;
    localparam S_IREF1 = 5'd11;
    localparam S_IREF2 = 5'd12;
    localparam S_IDLE = 5'd13;
    localparam S_AREF1 = 5'd14;
    localparam S_AREF2 = 5'd15;
    localparam S_SREF1 = 5'd16;
    localparam S_SREF2 = 5'd17;
    localparam S_SELF = 5'd18;
    reg [4:0] state_q, state_d;
    reg [4:0] cnt_q, cnt_d;
    reg [9:0] parms_q, parms_d;
    reg [GRP_W-1:0] grp_q, grp_d;
    reg [PER_W-1:0] timer_q, timer_d;
    reg pend_q, pend_d;
    reg [15:0] refcnt_q, refcnt_d;
    reg restart_q;
    reg force_q;
    reg csb_d, fn_d, pdb_d, acc_d;
    reg [14:0] ad_d;
    reg [1:0] ba_d;
    wire [GRP_W-1:0] grp_set = ref_parms[`DDRIR_GRP_HI:`DDRIR_GRP_LO];
    wire [PER_W-1:0] per_set = ref_parms[`DDRIR_PER_HI:`DDRIR_PER_LO];
    // Zero group means one; above eight is clamped
    wire [GRP_W-1:0] grp_eff = (grp_set == {GRP_W{1'b0}}) ?
        {{(GRP_W-1){1'b0}}, 1'b1} :
        (grp_set > `DDRIR_GROUP_MAX) ? `DDRIR_GROUP_MAX : grp_set;
    // Mode word from captured fields
    wire [14:0] mode_word = {7'h00, parms_q[`DDRIR_TEST_BIT],
        parms_q[`DDRIR_LAT_HI:`DDRIR_LAT_LO],
        parms_q[`DDRIR_ORDER_BIT],
        parms_q[`DDRIR_BSZ_HI:`DDRIR_BSZ_LO]};
    // Drive bit passed as given; user ties it low
    wire [14:0] ext_word = {13'h0000, parms_q[`DDRIR_DRIVE_BIT],
        parms_q[`DDRIR_DLL_BIT]};
    wire idle_free = (state_q == S_IDLE) && !access_busy;
    wire timer_hit = ref_auto_sel && (timer_q == {PER_W{1'b0}});
    ////////////////////////////////////////////////////////////////////////
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        parms_d = parms_q;
        grp_d = grp_q;
        refcnt_d = refcnt_q;
        csb_d = 1'b1;
        fn_d = `DDRIR_FN_WRITE;
        pdb_d = 1'b1;
        ad_d = mem_ad;
        ba_d = mem_ba;
        acc_d = 1'b0;
        // Expiry stays pending until a group starts; a force set in that cycle wins
        pend_d = pend_q || timer_hit || force_q;
        timer_d = timer_q;
        if (!ref_auto_sel) begin
            timer_d = per_set;
        end else if (timer_q != {PER_W{1'b0}}) begin
            timer_d = timer_q - {{(PER_W-1){1'b0}}, 1'b1};
        end
        case (state_q)
            S_LOCK: begin
                if (clock_manager_locked) begin
                    parms_d = init_parms;
                    ad_d = `DDRIR_RESET_ADDR;
                    ba_d = `DDRIR_BANK_MODE;
                    cnt_d = 5'd0;
                    state_d = S_DESELECT_CMD;
                end
            end
            S_DESELECT_CMD: begin
                cnt_d = cnt_q + 5'd1;
                if (cnt_q == `DDRIR_DESELECT_CMD_MIN - 5'd1) begin
                    state_d = S_RMRS1;
                end
            end
            S_RMRS1: begin
                csb_d = 1'b0;
                fn_d = `DDRIR_FN_READ;
                state_d = S_RMRS2;
            end
            S_HOLD1, S_HOLD2: begin
                cnt_d = cnt_q + 5'd1;
                if (cnt_q == `DDRIR_HOLD_MIN - 5'd1) begin
                    cnt_d = 5'd0;
                    state_d = (state_q == S_HOLD1) ? S_CHG : S_EMRS1;
                end
            end
            S_CHG: begin
                ad_d = `DDRIR_ALT_ADDR;
                state_d = S_HOLD2;
            end
            S_EMRS1, S_MRS1: begin
                csb_d = 1'b0;
                fn_d = `DDRIR_FN_READ;
                ad_d = (state_q == S_EMRS1) ? ext_word : mode_word;
                ba_d = (state_q == S_EMRS1) ? `DDRIR_BANK_EXT :
                    `DDRIR_BANK_MODE;
                state_d = state_q + 5'd1;
            end
            S_RMRS2, S_EMRS2, S_MRS2: begin
                csb_d = 1'b0;
                cnt_d = 5'd0;
                state_d = state_q + 5'd1;
            end
            S_IREF1, S_AREF1, S_SREF1: begin
                csb_d = 1'b0;
                fn_d = `DDRIR_FN_WRITE;
                state_d = state_q + 5'd1;
            end
            S_IREF2: begin
                csb_d = 1'b0;
                cnt_d = cnt_q + 5'd1;
                refcnt_d = refcnt_q + 16'h0001;
                state_d = S_IREF1;
                if (cnt_q == `DDRIR_INIT_REFS - 5'd1) begin
                    state_d = S_IDLE;
                end
            end
            S_IDLE: begin
                if (idle_free && pend_q) begin
                    // Pending wins; stale timer zero must not re-arm it
                    pend_d = force_q;
                    grp_d = grp_eff;
                    timer_d = per_set;
                    state_d = S_AREF1;
                end else if (idle_free && !ref_auto_sel &&
                             user_cmd == `DDRIR_CODE_AUTO_REF) begin
                    acc_d = 1'b1;
                    grp_d = {{(GRP_W-1){1'b0}}, 1'b1};
                    state_d = S_AREF1;
                end else if (idle_free && !ref_auto_sel &&
                             user_cmd == `DDRIR_CODE_SELF_REF) begin
                    acc_d = 1'b1;
                    state_d = S_SREF1;
                end
            end
            S_AREF2: begin
                csb_d = 1'b0;
                refcnt_d = refcnt_q + 16'h0001;
                grp_d = grp_q - {{(GRP_W-1){1'b0}}, 1'b1};
                state_d = (grp_q == {{(GRP_W-1){1'b0}}, 1'b1}) ?
                    S_IDLE : S_AREF1;
            end
            S_SREF2: begin
                csb_d = 1'b0;
                pdb_d = 1'b0;
                refcnt_d = refcnt_q + 16'h0001;
                state_d = S_SELF;
            end
            S_SELF: begin
                pdb_d = 1'b0;
                if (user_cmd != `DDRIR_CODE_SELF_REF) begin
                    pdb_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_LOCK;
            end
        endcase
        // Restart reruns the whole init; refreshes in flight are lost
        if (restart_q) begin
            state_d = S_LOCK;
            pdb_d = 1'b1;
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_LOCK;
            cnt_q <= 5'd0;
            parms_q <= 10'h000;
            grp_q <= {GRP_W{1'b0}};
            timer_q <= {PER_W{1'b0}};
            pend_q <= 1'b0;
            refcnt_q <= 16'h0000;
            mem_csb <= 1'b1;
            mem_fn <= 1'b0;
            mem_pdb <= 1'b1;
            mem_ad <= 15'h0000;
            mem_ba <= 2'h0;
            req_accept <= 1'b0;
            refresh_hold <= 1'b0;
            init_done <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            parms_q <= parms_d;
            grp_q <= grp_d;
            timer_q <= timer_d;
            pend_q <= pend_d;
            refcnt_q <= refcnt_d;
            mem_csb <= csb_d;
            mem_fn <= fn_d;
            mem_pdb <= pdb_d;
            mem_ad <= ad_d;
            mem_ba <= ba_d;
            req_accept <= acc_d;
            // Tells the access engine to take no new request
            refresh_hold <= pend_d || (state_d != S_IDLE);
            init_done <= (state_d >= S_IDLE);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; address and data taken in either order
    reg aw_got_q, w_got_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg wlane0_q;
    wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
    wire wr_ctrl = wr_go && (awaddr_q == `DDRIR_CTRL_OFS) && wlane0_q;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DDRIR_RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wlane0_q <= 1'b0;
            restart_q <= 1'b0;
            force_q <= 1'b0;
        end else begin
            restart_q <= wr_ctrl && wdata_q[`DDRIR_CTRL_RESTART];
            force_q <= wr_ctrl && wdata_q[`DDRIR_CTRL_FORCE_REF];
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wlane0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == `DDRIR_CTRL_OFS) ?
                    `DDRIR_RESP_OKAY : `DDRIR_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DDRIR_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DDRIR_RESP_OKAY;
                case (s_axi_araddr)
                    `DDRIR_CTRL_OFS: s_axi_rdata <= 32'h00000000;
                    `DDRIR_STATUS_OFS: s_axi_rdata <= {10'h000, parms_q,
                        2'h0, pend_q, init_done, 3'h0, state_q};
                    `DDRIR_REFCNT_OFS: s_axi_rdata <= {16'h0000, refcnt_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `DDRIR_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // ddrir_ctrl
`default_nettype wire

// ### ddrir_defines.vh
// Constants for the DDR init and refresh sequencer
`ifndef DDRIR_DEFINES_VH
`define DDRIR_DEFINES_VH

// Register byte offsets
`define DDRIR_CTRL_OFS 4'h0
`define DDRIR_STATUS_OFS 4'h4
`define DDRIR_REFCNT_OFS 4'h8
// Control register bits
`define DDRIR_CTRL_RESTART 0
`define DDRIR_CTRL_FORCE_REF 1
// AXI responses
`define DDRIR_RESP_OKAY 2'h0
`define DDRIR_RESP_SLVERR 2'h2

// Init parameter field positions
`define DDRIR_LAT_HI 9
`define DDRIR_LAT_LO 7
`define DDRIR_BSZ_HI 6
`define DDRIR_BSZ_LO 4
`define DDRIR_TEST_BIT 3
`define DDRIR_ORDER_BIT 2
`define DDRIR_DLL_BIT 1
`define DDRIR_DRIVE_BIT 0
// Refresh setting fields
`define DDRIR_GRP_HI 19
`define DDRIR_GRP_LO 16
`define DDRIR_PER_HI 15
`define DDRIR_PER_LO 0

// User request codes
`define DDRIR_CODE_SELF_REF 3'h5
`define DDRIR_CODE_AUTO_REF 3'h7

// Sequence counts
`define DDRIR_DESELECT_CMD_MIN 5'h0c
`define DDRIR_HOLD_MIN 5'h04
`define DDRIR_INIT_REFS 5'h02
`define DDRIR_GROUP_MAX 4'h8

// Memory addresses during the reset condition
`define DDRIR_RESET_ADDR 15'h0000
`define DDRIR_ALT_ADDR 15'h7fff
// Bank codes selecting mode or extended mode
`define DDRIR_BANK_MODE 2'h0
`define DDRIR_BANK_EXT 2'h1
// Function pin for first command of a pair
`define DDRIR_FN_WRITE 1'b0
`define DDRIR_FN_READ 1'b1

`endif

// ### ddrir_monitor.sv
// Assertion checker for the init and refresh sequencer
`timescale 1ns/1ps
`default_nettype none
module ddrir_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // User side
    input wire logic clock_manager_locked,
    input wire logic ref_auto_sel,
    input wire logic [2:0] user_cmd,
    input wire logic access_busy,
    input wire logic req_accept,
    input wire logic init_done,
    // Memory pins
    input wire logic mem_csb,
    input wire logic mem_fn,
    input wire logic mem_pdb
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Only codes 1x1 may be acknowledged, and only in manual mode
    wire user_ref = !ref_auto_sel && user_cmd[2] && user_cmd[0] && init_done;
    logic [4:0] init_cmds_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) init_cmds_q <= 5'h00;
        else if (init_done) init_cmds_q <= 5'h00;
        else if (!mem_csb) init_cmds_q <= init_cmds_q + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    // Last refresh command shows together with init_done
    init_count_a: assert property ($rose(init_done) |->
        !mem_csb && init_cmds_q == 5'h09)
        else $error("init command count wrong");
    lock_wait_a: assert property (!clock_manager_locked && !init_done |-> mem_csb)
        else $error("command before lock");
    pair_shape_a: assert property ($fell(mem_csb) |=> !mem_csb)
        else $error("command not sent as pair");
    // Pins follow the accept pulse by one cycle
    ack_pins_a: assert property (req_accept |=>
        !mem_csb && !mem_fn)
        else $error("accept without refresh command");
    ack_pulse_a: assert property (req_accept |=> !req_accept)
        else $error("accept longer than one cycle");
    ack_cause_a: assert property (req_accept |-> $past(user_ref))
        else $error("accept without user refresh code");
    self_hold_a: assert property (!mem_pdb && user_cmd == 3'h5 |=> !mem_pdb)
        else $error("self refresh left early");
    self_exit_a: assert property (!mem_pdb && user_cmd != 3'h5 |=> mem_pdb)
        else $error("self refresh not left");
    pdb_entry_a: assert property ($fell(mem_pdb) |-> !$past(mem_csb))
        else $error("power down not after refresh");
    busy_block_a: assert property (init_done && access_busy && mem_csb |=> mem_csb)
        else $error("refresh started while busy");
    cover property (req_accept);
    cover property ($fell(mem_pdb));
    cover property ($rose(init_done));
endmodule // ddrir_monitor
bind ddrir_ctrl ddrir_monitor i_ddrir_monitor (.clk(clk), .reset(reset),
    .clock_manager_locked(clock_manager_locked), .ref_auto_sel(ref_auto_sel),
    .user_cmd(user_cmd), .access_busy(access_busy), .req_accept(req_accept),
    .init_done(init_done), .mem_csb(mem_csb), .mem_fn(mem_fn),
    .mem_pdb(mem_pdb));
`default_nettype wire

// ### ddrir_mem_model.sv
// Memory-side model that decodes command pairs
`timescale 1ns/1ps
`default_nettype none
module ddrir_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command pins
    input wire logic mem_csb,
    input wire logic mem_fn,
    input wire logic [14:0] mem_ad,
    input wire logic [1:0] mem_ba,
    // Observations
    output logic [15:0] ref_cnt,
    output logic [14:0] ext_ad,
    output logic [14:0] mode_ad,
    output logic [4:0] last_run
);
    logic second_q;
    logic [4:0] run_q;
    // First half of a pair carries the function and the mode word
    wire first_cmd = !mem_csb && !second_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            second_q <= 1'b0;
            run_q <= 5'h00;
            ref_cnt <= 16'h0000;
            ext_ad <= 15'h0000;
            mode_ad <= 15'h0000;
            last_run <= 5'h00;
        end else begin
            second_q <= first_cmd;
            run_q <= mem_csb ? 5'h00 : run_q + 5'h01;
            if (mem_csb && run_q != 5'h00) last_run <= run_q;
            if (first_cmd && !mem_fn) ref_cnt <= ref_cnt + 16'h0001;
            if (first_cmd && mem_fn && mem_ba == 2'h1) ext_ad <= mem_ad;
            if (first_cmd && mem_fn && mem_ba == 2'h0) mode_ad <= mem_ad;
        end
    end
endmodule // ddrir_mem_model
`default_nettype wire

// ### ddrir_ctrl_tb.sv
// Self-checking bench for the init and refresh sequencer
`timescale 1ns/1ps
`default_nettype none
module ddrir_ctrl_tb;
    logic clk, reset, clock_manager_locked, ref_auto_sel, access_busy;
    logic [9:0] init_parms;
    logic [19:0] ref_parms;
    logic [2:0] user_cmd, lat, bsz;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, rd, rnd;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, mem_ba;
    wire [31:0] s_axi_rdata;
    wire req_accept, refresh_hold, init_done, mem_csb, mem_fn, mem_pdb;
    wire [14:0] mem_ad, ext_ad, mode_ad;
    wire [15:0] ref_cnt;
    wire [4:0] last_run;
    logic [15:0] r0;
    logic [1:0] resp;
    integer num_errors, n_compared, seed, i, k, g, n, gap;
    ddrir_ctrl #(.PER_W(16), .GRP_W(4)) i_ddrir_ctrl (.*);
    ddrir_mem_model i_ddrir_mem_model (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge clk);
    endtask
    task axw(input logic [3:0] a, input logic [31:0] d);
        logic w;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        w = 1'b1;
        for (int j = 0; j < 50 && w; j++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                resp = s_axi_bresp;
                w = 1'b0;
            end
        end
        chk(w, 0, "write wait");
    endtask
    task axr(input logic [3:0] a);
        logic w;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        w = 1'b1;
        for (int j = 0; j < 50 && w; j++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                w = 1'b0;
            end
        end
        chk(w, 0, "read wait");
    endtask
    // Whole run is about 600 cycles; allow over thirty times that
    initial begin
        #200000;
        num_errors = num_errors + 1;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h9e6f;
        num_errors = 0;
        n_compared = 0;
        reset = 1'b1;
        {clock_manager_locked, ref_auto_sel, access_busy} = 3'h0;
        {init_parms, user_cmd, s_axi_awaddr, s_axi_araddr} = 21'h0;
        ref_parms = 20'h10014;
        s_axi_wstrb = 4'hf;
        s_axi_wdata = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        cyc(2);
        reset <= 1'b0;
        cyc(6);
        // Latency codes 2 and 3 with burst size codes 1 and 2, via power-up then restart
        for (i = 0; i < 4; i++) begin
            lat = i[0] ? 3'h3 : 3'h2;
            bsz = i[1] ? 3'h2 : 3'h1;
            rnd = $random(seed);
            init_parms <= {lat, bsz, rnd[2:0], 1'b0};
            r0 = ref_cnt;
            if (i == 0) clock_manager_locked <= 1'b1;
            else axw(4'h0, 32'h1);
            for (k = 0; k < 5 && init_done; k++) @(posedge clk);
            for (k = 0; k < 300 && !init_done; k++) @(posedge clk);
            cyc(1);
            chk(init_done, 1, "init_done");
            chk(refresh_hold, 0, "hold idle");
            chk(ref_cnt - r0, 2, "init refs");
            chk(ext_ad, {13'h0, init_parms[0], init_parms[1]}, "ext");
            chk(mode_ad, {7'h0, init_parms[3], lat, init_parms[2], bsz},
                "mode");
            axr(4'h4);
            chk(rd[21:12], init_parms, "status parms");
        end
        axr(4'hc);
        chk(rd, 32'h0, "unmapped rdata");
        chk(resp, 2'h2, "unmapped read");
        axw(4'hc, 32'h1);
        chk(resp, 2'h2, "unmapped write");
        cyc(20); // Idle wait passes before any request
        // User auto refresh held off by a busy access, then accepted
        access_busy <= 1'b1;
        user_cmd <= 3'h7;
        cyc(10);
        chk(mem_csb, 1, "busy stall");
        r0 = ref_cnt;
        access_busy <= 1'b0;
        for (k = 0; k < 20 && !req_accept; k++) @(posedge clk);
        user_cmd <= 3'h0;
        cyc(3);
        chk(ref_cnt - r0, 1, "user ref");
        // Self refresh lasts as long as its code does
        user_cmd <= 3'h5;
        for (k = 0; k < 20 && !req_accept; k++) @(posedge clk);
        cyc(8);
        chk(mem_pdb, 0, "self pdb");
        user_cmd <= 3'h0;
        cyc(2);
        chk(mem_pdb, 1, "pdb exit");
        // Automatic groups: sizes 0, 1, 3, 8 and 9 with period 20
        for (i = 0; i < 5; i++) begin
            g = (32'h98310 >> (4 * i)) & 15;
            n = g == 0 ? 1 : (g > 8 ? 8 : g);
            ref_parms <= {g[3:0], 16'd20};
            ref_auto_sel <= 1'b1;
            access_busy <= 1'b1;
            cyc(30);
            chk(mem_csb, 1, "busy hold");
            chk(refresh_hold, 1, "hold pending");
            access_busy <= 1'b0;
            for (k = 0; k < 4 && mem_csb; k++) @(posedge clk);
            chk(mem_csb, 0, "ref start");
            for (k = 0; k < 40 && !mem_csb; k++) @(posedge clk);
            for (gap = 0; gap < 60 && mem_csb; gap++) @(posedge clk);
            chk(last_run, 2 * n, "group len");
            // Timer reloads at group start, so starts sit one period apart
            chk(2 * n + gap >= 20 && 2 * n + gap <= 23, 1, "period");
            for (k = 0; k < 40 && !mem_csb; k++) @(posedge clk);
            ref_auto_sel <= 1'b0;
            cyc(3);
        end
        // Forced group in manual mode, then the refresh counter
        r0 = ref_cnt;
        axw(4'h0, 32'h2);
        cyc(30);
        chk(ref_cnt - r0, n, "forced group");
        axr(4'h8);
        chk(rd, {16'h0, ref_cnt}, "refcnt");
        give_verdict;
    end
endmodule // ddrir_ctrl_tb
`default_nettype wire
